// >>> dual_adc_config_calibration_regs.sv
// Configuration and calibration register bank of a two-channel converter front end.
`timescale 1ns/100ps
`default_nettype none
`include "afe_cal_regs.svh"

module dual_adc_config_calibration_regs #(
  parameter logic [1:0] DEVICE_ADDR = 2'h0,
  parameter int GAIN_DELAY = `AFE_GAIN_DELAY_CLOCKS
) (
  // Clock and reset.
  input wire logic mclk,
  input wire logic rstn,
  // Serial port pins.
  input wire logic sck,
  input wire logic cs_n,
  input wire logic sdi,
  output logic sdo,
  output logic sdo_oe,
  // Raw converter codes.
  input wire afe_cal_pkg::code_t raw_code_ch0,
  input wire afe_cal_pkg::code_t raw_code_ch1,
  input wire logic raw_ready,
  // Reported codes.
  output afe_cal_pkg::code_t data_ch0,
  output afe_cal_pkg::code_t data_ch1,
  output logic data_ready,
  // Converter controls.
  output logic analog_master_clock_tick,
  output logic [12:0] oversampling_ratio,
  output logic [1:0] strength_field_a,
  output logic auto_zero_speed_bit,
  output logic [1:0] channel_reset,
  output logic [1:0] channel_shutdown,
  output logic internal_reference_enable,
  output logic crystal_oscillator_enable,
  output logic [7:0] reference_tempco_trim_value
);
  import afe_cal_pkg::*;

  if (GAIN_DELAY < 1 || GAIN_DELAY > 255) begin : gen_bad_delay
    $error("GAIN_DELAY must lie between 1 and 255");
  end

  function automatic byte_t reset_byte(input logic [4:0] a);
    unique case (a)
      `AFE_STATUS_HI: reset_byte = `AFE_STATUS_HI_RESET;
      `AFE_STATUS_LO: reset_byte = `AFE_STATUS_LO_RESET;
      `AFE_CONFIG_HI: reset_byte = `AFE_CONFIG_HI_RESET;
      `AFE_CONFIG_LO: reset_byte = `AFE_CONFIG_LO_RESET;
      `AFE_TEMPCO_TRIM: reset_byte = `AFE_TEMPCO_TRIM_RESET;
      default: reset_byte = 8'h00;
    endcase
  endfunction : reset_byte

  function automatic byte_t byte_mask(input logic [4:0] a);
    if (a < `AFE_REG_FIRST || a > `AFE_REG_LAST) begin
      byte_mask = 8'h00;
    end else if (a == `AFE_STATUS_HI) begin
      byte_mask = `AFE_STATUS_HI_MASK;
    end else if (a == `AFE_STATUS_LO) begin
      byte_mask = `AFE_STATUS_LO_MASK;
    end else if (a == `AFE_CONFIG_LO) begin
      byte_mask = `AFE_CONFIG_LO_MASK;
    end else begin
      byte_mask = 8'hff;
    end
  endfunction : byte_mask

  function automatic code_t sat24(input logic signed [25:0] v);
    if (v > 26'sh07fffff) begin
      sat24 = 24'h7fffff;
    end else if (v < -26'sh0800000) begin
      sat24 = 24'h800000;
    end else begin
      sat24 = v[23:0];
    end
  endfunction : sat24

  // Offset first, then gain; both saturate so a large correction cannot wrap the sign.
  function automatic code_t calibrate(input code_t raw, input code_t off, input code_t gain,
                                      input logic en_off, input logic en_gain);
    logic signed [25:0] sum;
    logic signed [47:0] prod;
    logic signed [25:0] scaled;
    code_t stage;
    sum = 26'($signed(raw)) + (en_off ? 26'($signed(off)) : 26'sh0000000);
    stage = sat24(sum);
    prod = $signed(stage) * $signed(gain);
    scaled = 26'($signed(stage)) + 26'(prod >>> `AFE_GAIN_FRAC_BITS);
    calibrate = en_gain ? sat24(scaled) : stage;
  endfunction : calibrate

  // Register map storage.
  byte_t map_byte [`AFE_REG_FIRST:`AFE_REG_LAST];
  byte_t next_map_byte [`AFE_REG_FIRST:`AFE_REG_LAST];

  function automatic byte_t read_byte(input logic [4:0] a);
    read_byte = 8'h00;
    if (a >= `AFE_REG_FIRST && a <= `AFE_REG_LAST) begin
      read_byte = map_byte[a] & byte_mask(a);
    end
  endfunction : read_byte

  // Serial access.
  byte_t rx_byte;
  logic rx_valid;
  logic frame_start;
  link_state_t state;
  link_state_t next_state;
  logic [4:0] addr;
  logic [4:0] next_addr;
  byte_t tx_byte;
  byte_t next_tx_byte;
  logic tx_load;
  logic next_tx_load;
  logic write_loop;

  serial_byte_port u_port (
    .mclk(mclk),
    .rstn(rstn),
    .sck(sck),
    .cs_n(cs_n),
    .sdi(sdi),
    .sdo(sdo),
    .sdo_oe(sdo_oe),
    .tx_byte(tx_byte),
    .tx_load(tx_load),
    .tx_enable(state == LINK_READ),
    .rx_byte(rx_byte),
    .rx_valid(rx_valid),
    .frame_start(frame_start)
  );

  assign write_loop = map_byte[`AFE_STATUS_LO][`AFE_WRITE_LOOP_BIT];

  always_comb begin
    next_state = state;
    next_addr = addr;
    next_tx_byte = tx_byte;
    next_tx_load = 1'b0;
    for (int i = `AFE_REG_FIRST; i <= `AFE_REG_LAST; i++) begin
      next_map_byte[i] = map_byte[i];
    end
    if (cs_n) begin
      next_state = LINK_IDLE;
    end else if (frame_start) begin
      next_state = LINK_CONTROL;
    end else if (rx_valid) begin
      unique case (state)
        LINK_CONTROL: begin
          next_addr = rx_byte[5:1];
          if (rx_byte[7:6] != DEVICE_ADDR) begin
            next_state = LINK_IGNORE;
          end else if (rx_byte[0]) begin
            next_state = LINK_READ;
            next_tx_byte = read_byte(rx_byte[5:1]);
            next_tx_load = 1'b1;
          end else begin
            next_state = LINK_WRITE;
          end
        end
        LINK_WRITE: begin
          if (addr >= `AFE_REG_FIRST && addr <= `AFE_REG_LAST) begin
            next_map_byte[addr] = rx_byte & byte_mask(addr);
          end
          if (write_loop) begin
            next_addr = (addr == `AFE_MAP_LAST) ? 5'h00 : addr + 5'h01;
          end
        end
        LINK_READ: begin
          next_addr = addr + 5'h01;
          next_tx_byte = read_byte(addr + 5'h01);
          next_tx_load = 1'b1;
        end
        LINK_IDLE, LINK_IGNORE: begin
          next_state = state;
        end
        default: begin
          next_state = LINK_IGNORE;
        end
      endcase
    end
  end

  for (genvar g = `AFE_REG_FIRST; g <= `AFE_REG_LAST; g++) begin : gen_map
    always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
        map_byte[g] <= reset_byte(5'(g));
      end else begin
        map_byte[g] <= next_map_byte[g];
      end
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state <= LINK_IDLE;
      addr <= 5'h00;
      tx_byte <= 8'h00;
      tx_load <= 1'b0;
    end else begin
      state <= next_state;
      addr <= next_addr;
      tx_byte <= next_tx_byte;
      tx_load <= next_tx_load;
    end
  end

  // Field views.
  byte_t status_lo;
  byte_t config_hi;
  byte_t config_lo;
  logic [1:0] width_sel;
  logic offset_correction_enable;
  logic gain_correction_enable;
  code_t offset_correction_value [2];
  code_t gain_correction_value [2];
  code_t raw_code [2];

  assign status_lo = map_byte[`AFE_STATUS_LO];
  assign config_hi = map_byte[`AFE_CONFIG_HI];
  assign config_lo = map_byte[`AFE_CONFIG_LO];
  assign width_sel = status_lo[`AFE_WIDTH_MSB:`AFE_WIDTH_LSB];
  assign offset_correction_enable = status_lo[`AFE_OFFSET_EN_BIT];
  assign gain_correction_enable = status_lo[`AFE_GAIN_EN_BIT];
  assign offset_correction_value[0] = {map_byte[5'h0e], map_byte[5'h0f], map_byte[5'h10]};
  assign gain_correction_value[0] = {map_byte[5'h11], map_byte[5'h12], map_byte[5'h13]};
  assign offset_correction_value[1] = {map_byte[5'h14], map_byte[5'h15], map_byte[5'h16]};
  assign gain_correction_value[1] = {map_byte[5'h17], map_byte[5'h18], map_byte[5'h19]};
  assign raw_code[0] = raw_code_ch0;
  assign raw_code[1] = raw_code_ch1;

  assign oversampling_ratio = `AFE_OVERSAMPLE_BASE << config_hi[`AFE_OVERSAMPLE_MSB:`AFE_OVERSAMPLE_LSB];
  assign strength_field_a = config_hi[`AFE_STRENGTH_FIELD_A_MSB:`AFE_STRENGTH_FIELD_A_LSB];
  assign auto_zero_speed_bit = config_hi[`AFE_AZ_BIT];
  assign channel_reset = config_lo[`AFE_CHRST_MSB:`AFE_CHRST_LSB];
  assign channel_shutdown = config_lo[`AFE_SHDN_MSB:`AFE_SHDN_LSB];
  assign internal_reference_enable = ~config_lo[`AFE_EXT_REF_BIT];
  assign crystal_oscillator_enable = ~config_lo[`AFE_EXT_CLK_BIT];
  assign reference_tempco_trim_value = map_byte[`AFE_TEMPCO_TRIM];

  // Analog clock prescaler: a one-cycle tick per analog period, since a divide-by-one clock cannot come from a flop.
  logic [2:0] pre_cnt;
  logic [2:0] next_pre_cnt;
  logic [2:0] pre_mask;
  logic next_tick;

  always_comb begin
    pre_mask = 3'((4'h1 << config_hi[`AFE_PRE_MSB:`AFE_PRE_LSB]) - 4'h1);
    next_pre_cnt = pre_cnt + 3'h1;
    next_tick = (next_pre_cnt & pre_mask) == 3'h0;
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      pre_cnt <= 3'h0;
      analog_master_clock_tick <= 1'b0;
    end else begin
      pre_cnt <= next_pre_cnt;
      analog_master_clock_tick <= next_tick;
    end
  end

  // Calibration path. A new raw sample during a pending gain delay restarts the delay.
  code_t result [2];
  code_t next_result [2];
  logic [7:0] delay_cnt;
  logic [7:0] next_delay_cnt;
  logic pending;
  logic next_pending;
  code_t next_data [2];
  logic next_data_ready;
  logic [1:0] narrow;

  assign narrow[0] = (width_sel == 2'h0);
  assign narrow[1] = (width_sel != 2'h3);

  for (genvar c = 0; c < 2; c++) begin : gen_chan
    always_comb begin
      next_result[c] = result[c];
      if (raw_ready) begin
        next_result[c] = calibrate(raw_code[c], offset_correction_value[c], gain_correction_value[c],
                                   offset_correction_enable, gain_correction_enable);
      end
    end
  end

  always_comb begin
    next_delay_cnt = delay_cnt;
    next_pending = pending;
    next_data_ready = 1'b0;
    next_data[0] = data_ch0;
    next_data[1] = data_ch1;
    if (raw_ready) begin
      next_pending = 1'b1;
      next_delay_cnt = gain_correction_enable ? 8'(GAIN_DELAY) : 8'h00;
    end else if (pending) begin
      if (delay_cnt == 8'h00) begin
        next_pending = 1'b0;
        next_data_ready = 1'b1;
        for (int k = 0; k < 2; k++) begin
          next_data[k] = narrow[k] ? {8'h00, result[k][23:8]} : result[k];
        end
      end else begin
        next_delay_cnt = delay_cnt - 8'h01;
      end
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      result[0] <= 24'h000000;
      result[1] <= 24'h000000;
      delay_cnt <= 8'h00;
      pending <= 1'b0;
      data_ready <= 1'b0;
      data_ch0 <= 24'h000000;
      data_ch1 <= 24'h000000;
    end else begin
      result[0] <= next_result[0];
      result[1] <= next_result[1];
      delay_cnt <= next_delay_cnt;
      pending <= next_pending;
      data_ready <= next_data_ready;
      data_ch0 <= next_data[0];
      data_ch1 <= next_data[1];
    end
  end

endmodule : dual_adc_config_calibration_regs

`default_nettype wire

// >>> afe_cal_regs.svh
// Register byte addresses, field positions, reset values and timing counts of the calibration bank.
`ifndef AFE_CAL_REGS_SVH
`define AFE_CAL_REGS_SVH

`define AFE_ADDR_W 5
`define AFE_MAP_LAST 5'h1f
`define AFE_REG_FIRST 5'h0a
`define AFE_REG_LAST 5'h1a

`define AFE_STATUS_HI 5'h0a
`define AFE_STATUS_LO 5'h0b
`define AFE_CONFIG_HI 5'h0c
`define AFE_CONFIG_LO 5'h0d
`define AFE_OFFSET_CH0 5'h0e
`define AFE_GAIN_CH0 5'h11
`define AFE_OFFSET_CH1 5'h14
`define AFE_GAIN_CH1 5'h17
`define AFE_TEMPCO_TRIM 5'h1a

`define AFE_STATUS_HI_RESET 8'h03
`define AFE_STATUS_LO_RESET 8'hb8
`define AFE_CONFIG_HI_RESET 8'h1e
`define AFE_CONFIG_LO_RESET 8'h02
`define AFE_TEMPCO_TRIM_RESET 8'h42
`define AFE_STATUS_HI_MASK 8'hdf
`define AFE_STATUS_LO_MASK 8'hfe
`define AFE_CONFIG_LO_MASK 8'hf6

`define AFE_WRITE_LOOP_BIT 5
`define AFE_WIDTH_MSB 4
`define AFE_WIDTH_LSB 3
`define AFE_OFFSET_EN_BIT 2
`define AFE_GAIN_EN_BIT 1
`define AFE_PRE_MSB 7
`define AFE_PRE_LSB 6
`define AFE_OVERSAMPLE_MSB 5
`define AFE_OVERSAMPLE_LSB 3
`define AFE_STRENGTH_FIELD_A_MSB 2
`define AFE_STRENGTH_FIELD_A_LSB 1
`define AFE_AZ_BIT 0
`define AFE_CHRST_MSB 7
`define AFE_CHRST_LSB 6
`define AFE_SHDN_MSB 5
`define AFE_SHDN_LSB 4
`define AFE_EXT_REF_BIT 2
`define AFE_EXT_CLK_BIT 1

`define AFE_OVERSAMPLE_BASE 13'h0020
`define AFE_GAIN_DELAY_CLOCKS 24
`define AFE_GAIN_FRAC_BITS 23

`endif

// >>> afe_cal_pkg.sv
// Types shared by the calibration register bank and its serial front end.
package afe_cal_pkg;

  typedef logic [7:0] byte_t;
  typedef logic [23:0] code_t;

  typedef enum logic [2:0] {
    LINK_IDLE = 3'b000,
    LINK_CONTROL = 3'b001,
    LINK_WRITE = 3'b010,
    LINK_READ = 3'b011,
    LINK_IGNORE = 3'b100
  } link_state_t;

endpackage : afe_cal_pkg

// >>> serial_byte_port.sv
// Serial port byte engine: shifts bytes in on rising clock edges and out on falling edges.
`timescale 1ns/100ps
`default_nettype none

module serial_byte_port (
  // Clock and reset.
  input wire logic mclk,
  input wire logic rstn,
  // Serial pins.
  input wire logic sck,
  input wire logic cs_n,
  input wire logic sdi,
  output logic sdo,
  output logic sdo_oe,
  // Byte side.
  input wire afe_cal_pkg::byte_t tx_byte,
  input wire logic tx_load,
  input wire logic tx_enable,
  output afe_cal_pkg::byte_t rx_byte,
  output logic rx_valid,
  output logic frame_start
);
  import afe_cal_pkg::*;

  logic sck_q;
  logic cs_q;
  logic [2:0] bit_cnt;
  byte_t shift_in;
  byte_t shift_out;
  logic next_sck_q;
  logic next_cs_q;
  logic [2:0] next_bit_cnt;
  byte_t next_shift_in;
  byte_t next_shift_out;
  byte_t next_rx_byte;
  logic next_rx_valid;
  logic next_frame_start;
  logic rise;
  logic fall;

  assign rise = sck & ~sck_q & ~cs_n;
  assign fall = ~sck & sck_q & ~cs_n;
  assign sdo = shift_out[7];
  assign sdo_oe = ~cs_n & tx_enable;

  always_comb begin
    next_sck_q = sck;
    next_cs_q = cs_n;
    next_bit_cnt = bit_cnt;
    next_shift_in = shift_in;
    next_shift_out = shift_out;
    next_rx_byte = rx_byte;
    next_rx_valid = 1'b0;
    next_frame_start = cs_q & ~cs_n;
    if (cs_n) begin
      next_bit_cnt = 3'h0;
    end else if (rise) begin
      next_shift_in = {shift_in[6:0], sdi};
      next_bit_cnt = bit_cnt + 3'h1;
      if (bit_cnt == 3'h7) begin
        next_rx_byte = {shift_in[6:0], sdi};
        next_rx_valid = 1'b1;
      end
    end
    // The falling edge that closes a byte must not shift: the next byte's first bit is already in place.
    if (tx_load) begin
      next_shift_out = tx_byte;
    end else if (fall && bit_cnt != 3'h0) begin
      next_shift_out = {shift_out[6:0], 1'b0};
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      sck_q <= 1'b0;
      cs_q <= 1'b1;
      bit_cnt <= 3'h0;
      shift_in <= 8'h00;
      shift_out <= 8'h00;
      rx_byte <= 8'h00;
      rx_valid <= 1'b0;
      frame_start <= 1'b0;
    end else begin
      sck_q <= next_sck_q;
      cs_q <= next_cs_q;
      bit_cnt <= next_bit_cnt;
      shift_in <= next_shift_in;
      shift_out <= next_shift_out;
      rx_byte <= next_rx_byte;
      rx_valid <= next_rx_valid;
      frame_start <= next_frame_start;
    end
  end

endmodule : serial_byte_port

`default_nettype wire

// >>> afe_cal_sva.sv
// Port-level checker for the calibration register bank.
`timescale 1ns/100ps
`default_nettype none
module afe_cal_sva #(
  parameter int GAIN_DELAY = 24
) (
  // Clock and reset.
  input wire logic mclk,
  input wire logic rstn,
  // Serial and converter side.
  input wire logic cs_n,
  input wire logic raw_ready,
  input wire afe_cal_pkg::code_t data_ch0,
  input wire afe_cal_pkg::code_t data_ch1,
  input wire logic data_ready,
  // Converter controls.
  input wire logic analog_master_clock_tick,
  input wire logic [12:0] oversampling_ratio,
  input wire logic [1:0] channel_reset,
  input wire logic crystal_oscillator_enable,
  input wire logic [7:0] reference_tempco_trim_value
);
  import afe_cal_pkg::*;
  localparam int LATE = GAIN_DELAY + 2;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  a_ratio_power: assert property ($onehot(oversampling_ratio) && oversampling_ratio >= 13'h0020)
    else $error("oversampling ratio is not a power of two from 32");
  a_ready_cause: assert property (data_ready |-> $past(raw_ready, 2) || $past(raw_ready, LATE))
    else $error("data ready without a sample at a legal distance");
  a_fixed_latency: assert property (raw_ready |-> (##2 data_ready) or (##LATE data_ready))
    else $error("sample not answered after the fixed latency");
  a_ready_single: assert property (data_ready |=> !data_ready)
    else $error("data ready longer than one cycle");
  a_data_hold: assert property (!data_ready |-> $stable(data_ch0) && $stable(data_ch1))
    else $error("reported data changed without data ready");
  a_tick_gap: assert property (!analog_master_clock_tick [*8] |-> 1'b0)
    else $error("analog clock tick gap above eight cycles");
  a_cfg_in_frame: assert property ($changed({oversampling_ratio, channel_reset, crystal_oscillator_enable})
    |-> !$past(cs_n)) else $error("configuration changed outside a frame");
  a_trim_in_frame: assert property ($changed(reference_tempco_trim_value) |-> !$past(cs_n))
    else $error("trim changed outside a frame");

  c_plain: cover property (raw_ready ##2 data_ready);
  c_late: cover property (raw_ready ##LATE data_ready);
  c_trim: cover property ($changed(reference_tempco_trim_value));
endmodule : afe_cal_sva

bind dual_adc_config_calibration_regs afe_cal_sva #(.GAIN_DELAY(GAIN_DELAY)) checker_i (.mclk(mclk), .rstn(rstn),
  .cs_n(cs_n), .raw_ready(raw_ready), .data_ch0(data_ch0), .data_ch1(data_ch1), .data_ready(data_ready),
  .analog_master_clock_tick(analog_master_clock_tick), .oversampling_ratio(oversampling_ratio),
  .channel_reset(channel_reset), .crystal_oscillator_enable(crystal_oscillator_enable),
  .reference_tempco_trim_value(reference_tempco_trim_value));
`default_nettype wire

// >>> host_port_model.sv
// Host-side serial master that frames byte transfers to the bank, mode 0, MSB first.
`timescale 1ns/100ps
`default_nettype none
module host_port_model (
  // Clock.
  input wire logic mclk,
  // Serial pins.
  output logic sck,
  output logic cs_n,
  output logic sdi,
  input wire logic sdo
);
  import afe_cal_pkg::*;
  // Five clocks a phase cover the port's edge sampling and the read load delay of three clocks.
  localparam int PHASE = 5;

  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    sdi = 1'b0;
  end

  task automatic shift_byte(input byte_t tx, output byte_t rx);
    for (int i = 7; i >= 0; i--) begin
      sdi = tx[i];
      repeat (PHASE) @(negedge mclk);
      rx[i] = sdo;
      sck = 1'b1;
      repeat (PHASE) @(negedge mclk);
      sck = 1'b0;
    end
  endtask : shift_byte

  task automatic open_frame(input logic [1:0] dev, input logic [4:0] addr, input logic rd, output byte_t rx);
    cs_n = 1'b0;
    repeat (PHASE) @(negedge mclk);
    shift_byte({dev, addr, rd}, rx);
  endtask : open_frame

  task automatic close_frame();
    cs_n = 1'b1;
    // The data line is not left at its last bit, so a stale value can never look valid.
    sdi = ~sdi;
    repeat (PHASE) @(negedge mclk);
  endtask : close_frame
endmodule : host_port_model
`default_nettype wire

// >>> testbench.sv
// Self-checking bench for the calibration register bank.
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import afe_cal_pkg::*;
  localparam int GD = 24;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic raw_ready = 1'b0;
  logic sck, cs_n, sdi, sdo, sdo_oe, data_ready, tick, az, iref, xtal;
  code_t raw0 = 24'h000000;
  code_t raw1 = 24'h000000;
  code_t data_ch0, data_ch1;
  logic [12:0] ratio;
  logic [1:0] dith, chrst, shdn;
  byte_t trim;
  int fail_count = 0;
  int n_compared = 0;

  always #20 mclk = ~mclk;

  host_port_model host (.mclk(mclk), .sck(sck), .cs_n(cs_n), .sdi(sdi), .sdo(sdo));
  dual_adc_config_calibration_regs #(.DEVICE_ADDR(2'h0), .GAIN_DELAY(GD)) dut (.mclk(mclk), .rstn(rstn),
    .sck(sck), .cs_n(cs_n), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe), .raw_code_ch0(raw0), .raw_code_ch1(raw1),
    .raw_ready(raw_ready), .data_ch0(data_ch0), .data_ch1(data_ch1), .data_ready(data_ready),
    .analog_master_clock_tick(tick), .oversampling_ratio(ratio), .strength_field_a(dith), .auto_zero_speed_bit(az),
    .channel_reset(chrst), .channel_shutdown(shdn), .internal_reference_enable(iref),
    .crystal_oscillator_enable(xtal), .reference_tempco_trim_value(trim));

  task automatic check(input logic [23:0] seen, input logic [23:0] want, input string what);
    n_compared++;
    if (seen !== want) begin
      fail_count++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, want);
    end
  endtask : check

  task automatic wr(input logic [1:0] dev, input logic [4:0] a, input byte_t d[$]);
    byte_t rx;
    host.open_frame(dev, a, 1'b0, rx);
    foreach (d[i]) host.shift_byte(d[i], rx);
    host.close_frame();
  endtask : wr

  task automatic rd(input logic [4:0] a, input byte_t want[$]);
    byte_t rx;
    host.open_frame(2'h0, a, 1'b1, rx);
    foreach (want[i]) begin
      host.shift_byte(8'h00, rx);
      check(rx, want[i], "read byte");
    end
    host.close_frame();
  endtask : rd

  // Floor shift on the product, as the gain stage truncates rather than rounds.
  function automatic code_t expect_code(code_t raw, code_t off, code_t gain, logic [1:0] en, logic narrow);
    logic signed [47:0] c;
    c = $signed(raw) + (en[0] ? $signed(off) : 48'sd0);
    if (en[1]) c = c + ((c * $signed(gain)) >>> 23);
    return narrow ? {8'h00, c[23:8]} : c[23:0];
  endfunction : expect_code

  task automatic t_reset();
    check(ratio, 13'h0100, "ratio");
    check(dith, 2'h3, "strength_field_a");
    check(az, 1'b0, "auto zero");
    check({chrst, shdn}, 4'h0, "reset shutdown");
    check({iref, xtal}, 2'b10, "reference clock");
    check(trim, 8'h42, "trim");
    rd(5'h0b, '{8'hb8, 8'h1e, 8'h02});
    rd(5'h19, '{8'h00, 8'h42, 8'h00, 8'h00});
  endtask : t_reset

  task automatic t_config();
    logic [2:0] k;
    int ticks;
    for (int i = 0; i < 8; i++) begin
      k = 3'(i);
      wr(2'h0, 5'h0c, '{{k[1:0], k, k[1:0], k[0]}, {k[1:0], k[2:1], 1'b1, k[1], k[0], 1'b1}});
      check(ratio, 13'h0020 << k, "ratio");
      check(dith, k[1:0], "strength_field_a");
      check(az, k[0], "auto zero");
      check(chrst, k[1:0], "channel reset");
      check(shdn, k[2:1], "shutdown");
      check(iref, !k[1], "internal reference");
      check(xtal, !k[0], "crystal");
      rd(5'h0d, '{{k[1:0], k[2:1], 1'b0, k[1], k[0], 1'b0}});
      ticks = 0;
      repeat (64) @(negedge mclk) ticks += int'(tick === 1'b1);
      check(24'(ticks), 24'(64 >> k[1:0]), "tick count");
    end
  endtask : t_config

  task automatic t_loop();
    byte_t rx;
    wr(2'h0, 5'h0b, '{8'h98});
    wr(2'h0, 5'h1a, '{8'h11, 8'h5c});
    check(trim, 8'h5c, "trim held");
    wr(2'h1, 5'h1a, '{8'h00});
    check(trim, 8'h5c, "foreign write");
    host.open_frame(2'h2, 5'h1a, 1'b1, rx);
    check(sdo_oe, 1'b0, "foreign read");
    host.close_frame();
    wr(2'h0, 5'h0b, '{8'hb8});
  endtask : t_loop

  task automatic t_cal();
    logic [1:0] k;
    int n;
    wr(2'h0, 5'h0c, '{8'h1e, 8'h02});
    wr(2'h0, 5'h0e, '{8'h00, 8'h01, 8'h00, 8'h40, 8'h00, 8'h00, 8'hff, 8'hff, 8'h00, 8'hc0, 8'h00, 8'h00});
    raw0 = 24'h123456;
    raw1 = 24'hfedcba;
    for (int i = 0; i < 4; i++) begin
      k = 2'(i);
      wr(2'h0, 5'h0b, '{{3'b101, k, k, 1'b1}});
      raw_ready = 1'b1;
      @(negedge mclk);
      raw_ready = 1'b0;
      n = 0;
      while (data_ready !== 1'b1 && n < 60) begin
        @(negedge mclk);
        n++;
      end
      // Counted from the falling edge after the sampling edge, so the register stage shows as one cycle.
      check(24'(n), 24'(k[0] ? GD + 1 : 1), "latency");
      check(data_ch0, expect_code(raw0, 24'h000100, 24'h400000, {k[0], k[1]}, k == 2'h0), "ch0");
      check(data_ch1, expect_code(raw1, 24'hffff00, 24'hc00000, {k[0], k[1]}, k != 2'h3), "ch1");
    end
  endtask : t_cal

  task automatic report_and_stop();
    if (fail_count == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : report_and_stop

  initial begin
    repeat (20) @(negedge mclk);
    rstn = 1'b1;
    @(negedge mclk);
    t_reset();
    t_config();
    t_loop();
    t_cal();
    report_and_stop();
  end

  // The sequence needs about 7500 clocks; eight times that means a hang.
  initial begin
    repeat (60000) @(negedge mclk);
    fail_count++;
    report_and_stop();
  end
endmodule : testbench
`default_nettype wire
